// file: rtl/flsw_pkg.sv
package flsw_pkg;

    // status register layout
    localparam int STAT_BUSY = 0;
    localparam int STAT_WEL = 1;
    localparam int STAT_BP_LO = 2;
    localparam int STAT_BP_HI = 5;
    localparam int STAT_QUAD = 6;
    localparam int STAT_LOCK = 7;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [3:0] BP_NONE = 4'h0;

    // link framing
    localparam logic [3:0] BIT_OPC_LAST = 4'h7;
    localparam logic [3:0] BIT_DAT_LAST = 4'hF;
    localparam logic [2:0] OUT_IDX_FIRST = 3'h7;

    // busy duration of one program, erase or register write, in clock cycles
    localparam int OP_CYCLES_DEF = 64;

    // instruction codes
    localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] FUNCTION_READ_CMD = 8'h48;
    localparam logic [7:0] RESET_ENABLE_CMD = 8'h66;
    localparam logic [7:0] RESET_CMD = 8'h99;
    localparam logic [7:0] SUSPEND_CMD = 8'h75;
    localparam logic [7:0] SUSPEND_ALT_CMD = 8'hB0;
    localparam logic [7:0] RESUME_CMD = 8'h7A;
    localparam logic [7:0] RESUME_ALT_CMD = 8'h30;
    localparam logic [7:0] FULL_ERASE_CMD = 8'hC7;
    localparam logic [7:0] FULL_ERASE_ALT_CMD = 8'h60;

    // program and erase: suspendable
    function automatic logic is_pe_op(input logic [7:0] op);
        case (op)
            8'h02, 8'h12, 8'h32, 8'h34, 8'h38, 8'h3E,
            8'hD7, 8'h20, 8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC,
            8'hC7, 8'h60: is_pe_op = 1'b1;
            default: is_pe_op = 1'b0;
        endcase
    endfunction : is_pe_op

    // operations that hold the busy flag
    function automatic logic is_busy_op(input logic [7:0] op);
        case (op)
            8'h01, 8'h42, 8'h65, 8'h85, 8'h64, 8'h62, 8'h15, 8'h18,
            8'hFD, 8'hE3, 8'hE4, 8'h2F, 8'hA6, 8'h7E, 8'h98, 8'hE8,
            8'h43: is_busy_op = 1'b1;
            default: is_busy_op = is_pe_op(op);
        endcase
    endfunction : is_busy_op

    // volatile register writes: done at once, no busy time
    function automatic logic is_vol_write(input logic [7:0] op);
        case (op)
            8'h63, 8'h83, 8'hC5, 8'hFB, 8'hE1, 8'h4A, 8'h91,
            8'hC0, 8'h17: is_vol_write = 1'b1;
            default: is_vol_write = 1'b0;
        endcase
    endfunction : is_vol_write

    // the write-enable-required set
    function automatic logic needs_wel(input logic [7:0] op);
        case (op)
            8'hC0, 8'h17: needs_wel = 1'b0;
            default: needs_wel = is_busy_op(op) | is_vol_write(op);
        endcase
    endfunction : needs_wel

endpackage : flsw_pkg

// file: rtl/flsw_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface flsw_sync_if #(parameter int WIDTH = 1);
    logic [WIDTH-1:0] d;
    logic [WIDTH-1:0] q;
    modport src(output d, input q);
    modport dst(input d, output q);
endinterface : flsw_sync_if
`default_nettype wire

// file: rtl/flsw_sync.sv
`timescale 1ns/1ps
`default_nettype none
module flsw_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic resetn,
    flsw_sync_if.dst link
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    meta_r[i] <= 1'b0;
                    sync_r[i] <= 1'b0;
                end else begin
                    meta_r[i] <= link.d[i];
                    sync_r[i] <= meta_r[i];
                end
            end
        end
    endgenerate

    assign link.q = sync_r;
endmodule : flsw_sync
`default_nettype wire

// file: rtl/flsw_status_we.sv
`timescale 1ns/1ps
`default_nettype none
module flsw_status_we #(
    parameter int OP_CYCLES = flsw_pkg::OP_CYCLES_DEF
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic link_sclk,
    input wire logic link_cs_n,
    input wire logic link_si,
    output logic link_so_o,
    output logic link_so_oe,
    input wire logic data_line_2_i,
    output logic data_line_2_o,
    output logic data_line_2_oe,
    input wire logic data_line_3_i,
    output logic data_line_3_o,
    output logic data_line_3_oe,
    output logic [7:0] flash_status,
    output logic quad_mode,
    output logic protect_any,
    output logic op_start,
    output logic [7:0] op_code,
    output logic [7:0] op_data
);
    localparam int CW = (OP_CYCLES > 1) ? $clog2(OP_CYCLES) : 1;
    localparam logic [CW-1:0] OP_LOAD = CW'(OP_CYCLES - 1);
    localparam logic [CW-1:0] CNT_ZERO = '0;

    // link side (link_sclk)
    logic frame_end;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] op_r;
    logic rd_active_r;
    logic [7:0] shift_nxt;
    logic cmd_tgl_r;
    logic [7:0] cmd_op_r;
    logic [7:0] cmd_dat_r;
    logic pub_seen_r;
    logic [7:0] copy_r;
    logic [2:0] out_idx_r;
    logic so_r;
    logic so_pick;
    logic opc_done;
    logic dat_done;

    // system side (clock)
    logic [5:0] nv_r;
    logic wel_r;
    logic busy_r;
    logic op_act_r;
    logic susp_r;
    logic rst_en_r;
    logic [CW-1:0] op_cnt_r;
    logic [7:0] cur_op_r;
    logic cmd_seen_r;
    logic pub_tgl_r;
    logic [7:0] pub_r;
    logic op_start_r;
    logic [7:0] op_code_r;
    logic [7:0] op_data_r;
    logic [5:0] nv_nxt;
    logic wel_nxt;
    logic op_act_nxt;
    logic susp_nxt;
    logic rst_en_nxt;
    logic [CW-1:0] op_cnt_nxt;
    logic [7:0] cur_op_nxt;

    flsw_sync_if #(.WIDTH(3)) sys_sy ();
    flsw_sync_if #(.WIDTH(1)) lnk_sy ();

    flsw_sync #(.WIDTH(3)) u_sys_sync (
        .clock(clock),
        .resetn(resetn),
        .link(sys_sy)
    );

    flsw_sync #(.WIDTH(1)) u_lnk_sync (
        .clock(link_sclk),
        .resetn(resetn),
        .link(lnk_sy)
    );

    // frame logic is cleared by chip enable high, since sclk stops between frames
    assign frame_end = link_cs_n | ~resetn;
    assign shift_nxt = {shift_r[6:0], link_si};
    assign opc_done = (bit_cnt_r == flsw_pkg::BIT_OPC_LAST);
    assign dat_done = (bit_cnt_r == flsw_pkg::BIT_DAT_LAST)
        && (op_r == flsw_pkg::STATUS_WRITE_CMD);

    always_ff @(posedge link_sclk or posedge frame_end) begin
        if (frame_end) begin
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            op_r <= 8'h00;
            rd_active_r <= 1'b0;
        end else begin
            shift_r <= shift_nxt;
            if (bit_cnt_r != flsw_pkg::BIT_DAT_LAST) begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            if (opc_done) begin
                op_r <= shift_nxt;
                rd_active_r <= (shift_nxt == flsw_pkg::STATUS_READ_CMD);
            end
        end
    end

    // command word stays put until the next command completes
    always_ff @(posedge link_sclk or negedge resetn) begin
        if (!resetn) begin
            cmd_tgl_r <= 1'b0;
            cmd_op_r <= 8'h00;
            cmd_dat_r <= 8'h00;
        end else if (opc_done && shift_nxt != flsw_pkg::STATUS_WRITE_CMD) begin
            cmd_op_r <= shift_nxt;
            cmd_tgl_r <= ~cmd_tgl_r;
        end else if (dat_done) begin
            cmd_op_r <= op_r;
            cmd_dat_r <= shift_nxt;
            cmd_tgl_r <= ~cmd_tgl_r;
        end
    end

    // status copy arrives by toggle handshake; it may lag by a few link edges
    assign lnk_sy.d = pub_tgl_r;
    always_ff @(posedge link_sclk or negedge resetn) begin
        if (!resetn) begin
            pub_seen_r <= 1'b0;
            copy_r <= flsw_pkg::STAT_RESET;
        end else if (lnk_sy.q[0] != pub_seen_r) begin
            pub_seen_r <= lnk_sy.q[0];
            copy_r <= pub_r;
        end
    end

    assign so_pick = copy_r[out_idx_r];
    always_ff @(negedge link_sclk or posedge frame_end) begin
        if (frame_end) begin
            out_idx_r <= flsw_pkg::OUT_IDX_FIRST;
            so_r <= 1'b0;
        end else if (rd_active_r) begin
            so_r <= so_pick;
            out_idx_r <= out_idx_r - 3'h1; // wraps 0 to 7
        end
    end

    assign link_so_o = so_r;
    assign link_so_oe = rd_active_r;

    // system side decode
    wire cmd_tgl_s = sys_sy.q[2];
    wire ack_s = sys_sy.q[1];
    wire wp_pin_s = sys_sy.q[0];
    assign sys_sy.d = {cmd_tgl_r, pub_seen_r, data_line_2_i};

    wire [7:0] cmd = cmd_op_r;
    wire cmd_evt = (cmd_tgl_s != cmd_seen_r);
    wire [3:0] bp = nv_r[3:0];
    wire lockout = nv_r[5];
    wire quad = nv_r[4];
    wire wp_level = quad | wp_pin_s;
    wire busy_w = op_act_r & ~susp_r;
    wire is_susp = (cmd == flsw_pkg::SUSPEND_CMD) || (cmd == flsw_pkg::SUSPEND_ALT_CMD);
    wire is_resume = (cmd == flsw_pkg::RESUME_CMD) || (cmd == flsw_pkg::RESUME_ALT_CMD);
    wire pe_running = op_act_r & flsw_pkg::is_pe_op(cur_op_r);
    wire busy_ok = (cmd == flsw_pkg::STATUS_READ_CMD) || (cmd == flsw_pkg::FUNCTION_READ_CMD)
        || (cmd == flsw_pkg::RESET_ENABLE_CMD) || (cmd == flsw_pkg::RESET_CMD)
        || (is_susp && pe_running);
    wire gate_busy = busy_w & ~busy_ok;
    wire gate_wel = flsw_pkg::needs_wel(cmd) & ~wel_r;
    wire is_full_erase = (cmd == flsw_pkg::FULL_ERASE_CMD) || (cmd == flsw_pkg::FULL_ERASE_ALT_CMD);
    wire gate_ce = is_full_erase && (bp != flsw_pkg::BP_NONE);
    wire is_status_write_cmd = (cmd == flsw_pkg::STATUS_WRITE_CMD);
    wire gate_lock = is_status_write_cmd & lockout & ~wp_level;
    wire gate_susp = susp_r & flsw_pkg::is_busy_op(cmd);
    wire accept = cmd_evt & ~(gate_busy | gate_wel | gate_ce | gate_lock | gate_susp);
    wire start = accept & flsw_pkg::is_busy_op(cmd);
    wire op_done = busy_w && (op_cnt_r == CNT_ZERO);
    wire rst_go = accept && (cmd == flsw_pkg::RESET_CMD) && rst_en_r;
    wire [7:0] status_w = {nv_r, wel_r, busy_r};

    always_comb begin
        nv_nxt = nv_r;
        wel_nxt = wel_r;
        op_act_nxt = op_act_r;
        susp_nxt = susp_r;
        op_cnt_nxt = op_cnt_r;
        cur_op_nxt = cur_op_r;
        rst_en_nxt = accept ? (cmd == flsw_pkg::RESET_ENABLE_CMD) : rst_en_r;
        if (busy_w && op_cnt_r != CNT_ZERO) begin
            op_cnt_nxt = op_cnt_r - 1'b1;
        end
        if (op_done) begin
            op_act_nxt = 1'b0;
            wel_nxt = 1'b0;
        end
        if (accept && cmd == flsw_pkg::WRITE_ENABLE_CMD) begin
            wel_nxt = 1'b1;
        end
        if (accept && cmd == flsw_pkg::WRITE_DISABLE_CMD) begin
            wel_nxt = 1'b0;
        end
        if (accept && is_status_write_cmd) begin
            nv_nxt = cmd_dat_r[flsw_pkg::STAT_LOCK:flsw_pkg::STAT_BP_LO];
        end
        if (start) begin
            op_act_nxt = 1'b1;
            op_cnt_nxt = OP_LOAD;
            cur_op_nxt = cmd;
        end
        // a suspend landing on the completing cycle must not leave a stale suspend behind
        if (accept && is_susp && pe_running && !op_done) begin
            susp_nxt = 1'b1;
        end
        if (accept && is_resume && susp_r) begin
            susp_nxt = 1'b0;
        end
        // a reset aborts the operation in flight
        if (rst_go) begin
            wel_nxt = 1'b0;
            op_act_nxt = 1'b0;
            susp_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            nv_r <= 6'h00;
            wel_r <= 1'b0;
            busy_r <= 1'b0;
            op_act_r <= 1'b0;
            susp_r <= 1'b0;
            rst_en_r <= 1'b0;
            op_cnt_r <= CNT_ZERO;
            cur_op_r <= 8'h00;
            cmd_seen_r <= 1'b0;
        end else begin
            nv_r <= nv_nxt;
            wel_r <= wel_nxt;
            busy_r <= op_act_nxt & ~susp_nxt;
            op_act_r <= op_act_nxt;
            susp_r <= susp_nxt;
            rst_en_r <= rst_en_nxt;
            op_cnt_r <= op_cnt_nxt;
            cur_op_r <= cur_op_nxt;
            cmd_seen_r <= cmd_tgl_s;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            op_start_r <= 1'b0;
            op_code_r <= 8'h00;
            op_data_r <= 8'h00;
        end else begin
            op_start_r <= start | (accept & flsw_pkg::is_vol_write(cmd));
            op_code_r <= accept ? cmd : op_code_r;
            op_data_r <= accept ? cmd_dat_r : op_data_r;
        end
    end

    // republish only when the link side has taken the previous copy
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pub_tgl_r <= 1'b0;
            pub_r <= flsw_pkg::STAT_RESET;
        end else if (ack_s == pub_tgl_r && pub_r != status_w) begin
            pub_r <= status_w;
            pub_tgl_r <= ~pub_tgl_r;
        end
    end

    assign flash_status = status_w;
    assign quad_mode = nv_r[4];
    assign protect_any = (bp != flsw_pkg::BP_NONE);
    assign op_start = op_start_r;
    assign op_code = op_code_r;
    assign op_data = op_data_r;
    // quad transfers are not handled here, so pins 2 and 3 are never driven
    assign data_line_2_o = 1'b0;
    assign data_line_2_oe = 1'b0;
    assign data_line_3_o = data_line_3_i & 1'b0;
    assign data_line_3_oe = 1'b0;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_status_write_cmd_taken;
        accept && is_status_write_cmd;
    endsequence
    sequence s_op_end;
        busy_w && (op_cnt_r == CNT_ZERO);
    endsequence

    a_wel_set: assert property (accept && cmd == flsw_pkg::WRITE_ENABLE_CMD |=> wel_r)
        else $error("write latch not set");
    a_wel_clear: assert property (accept && cmd == flsw_pkg::WRITE_DISABLE_CMD |=> !wel_r)
        else $error("write latch not cleared");
    a_done_busy: assert property (s_op_end |=> !flash_status[0] && !op_act_r)
        else $error("busy flag stuck after completion");
    a_done_latch: assert property (op_done |=> !wel_r)
        else $error("write latch not cleared at completion");
    a_status_write_cmd_latch: assert property (s_status_write_cmd_taken |=> wel_r == $past(wel_r))
        else $error("status write changed the write latch");
    a_status_write_cmd_load: assert property (s_status_write_cmd_taken
        |=> nv_r == $past(cmd_dat_r[flsw_pkg::STAT_LOCK:flsw_pkg::STAT_BP_LO]))
        else $error("status write did not load bits");
    a_busy_start: assert property (start |=> flash_status[0] && op_act_r)
        else $error("busy flag not raised");
    a_busy_drop: assert property (cmd_evt && gate_busy |=> !op_start_r && $stable(nv_r))
        else $error("instruction taken while busy");
    a_no_latch: assert property (cmd_evt && gate_wel |=> !op_start_r && !$changed(nv_r))
        else $error("guarded opcode ran without latch");
    a_full_erase: assert property (cmd_evt && gate_ce |=> !op_start_r)
        else $error("full erase ran with protect bits set");
    a_lock_hold: assert property (cmd_evt && gate_lock |=> $stable(nv_r) ##1 $stable(nv_r))
        else $error("locked status register was written");
    a_suspend_take: assert property (accept && is_susp && pe_running |=> !flash_status[0])
        else $error("suspend not taken during program");
    a_read_repeat: assert property (@(negedge link_sclk) disable iff (frame_end)
        rd_active_r |=> link_so_o == $past(so_pick))
        else $error("status read bit out of order");

endmodule : flsw_status_we
`default_nettype wire

// file: bench/flsw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module flsw_host_model (
    output logic link_sclk,
    output logic link_cs_n,
    output logic link_si,
    input wire logic link_so,
    output logic rd_strobe,
    output logic [7:0] rd_byte
);
    logic [7:0] rx;
    initial begin
        link_sclk = 1'b0;
        link_cs_n = 1'b1;
        link_si = 1'b0;
        rd_strobe = 1'b0;
        rd_byte = 8'h00;
        rx = 8'h00;
    end
    // opcode, nb bytes of dat, then rd bytes read; sclk stands still between frames
    task automatic xfer(input logic [7:0] op, input logic [7:0] dat, input int nb, input int rd);
        logic [7:0] b;
        link_cs_n = 1'b0;
        for (int i = 0; i < 8 * (1 + nb + rd); i++) begin
            b = (i < 8) ? op : dat;
            link_si = b[7 - (i % 8)];
            #3 link_sclk = 1'b1;
            rx = {rx[6:0], link_so};
            // first two read bytes skipped: the read copy may lag a few edges
            if (i >= 8 * (3 + nb) && i % 8 == 7) begin
                rd_byte = rx;
                rd_strobe = 1'b1;
            end
            #3 link_sclk = 1'b0;
            rd_strobe = 1'b0;
        end
        #3 link_cs_n = 1'b1;
        link_si = ~link_si;
        // long deselect keeps commands well apart
        #200;
    endtask : xfer
endmodule : flsw_host_model
`default_nettype wire

// file: bench/flash_status_write_enable_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module flash_status_write_enable_tb_top;
    logic clock, resetn, wp_drive, hold_drive, sclk, cs_n, si, so_o, so_oe, so_w, last_so;
    logic d2_o, d2_oe, d3_o, d3_oe, d2_w, d3_w, op_start, quad_mode, protect_any, rd_strobe;
    logic [7:0] flash_status, op_code, op_data, rd_byte, d;
    logic [7:0] exp_q[$];
    logic [7:0] guard_ops [6] = '{8'h02, 8'h20, 8'h42, 8'hFD, 8'h64, 8'h43};
    int fail_count, tests_run, n_ops, seed, k;

    assign d2_w = d2_oe ? d2_o : wp_drive;
    assign d3_w = d3_oe ? d3_o : hold_drive;
    // released output shows the inverse of its last bit, never a stale copy
    assign so_w = so_oe ? so_o : ~last_so;
    always @(so_o or so_oe) if (so_oe === 1'b1) last_so = so_o;

    flsw_status_we #(.OP_CYCLES(60)) flsw_status_we_i (
        .clock(clock), .resetn(resetn), .link_sclk(sclk), .link_cs_n(cs_n),
        .link_si(si), .link_so_o(so_o), .link_so_oe(so_oe),
        .data_line_2_i(d2_w), .data_line_2_o(d2_o), .data_line_2_oe(d2_oe),
        .data_line_3_i(d3_w), .data_line_3_o(d3_o), .data_line_3_oe(d3_oe),
        .flash_status(flash_status), .quad_mode(quad_mode), .protect_any(protect_any),
        .op_start(op_start), .op_code(op_code), .op_data(op_data)
    );
    flsw_host_model flsw_host_model_i (
        .link_sclk(sclk), .link_cs_n(cs_n), .link_si(si), .link_so(so_w),
        .rd_strobe(rd_strobe), .rd_byte(rd_byte)
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // counted on the falling edge, away from the edge that launches the pulse
    always @(negedge clock) if (op_start === 1'b1) n_ops++;

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict

    task automatic cmd(input logic [7:0] op, input logic [7:0] dat, input int nb);
        flsw_host_model_i.xfer(op, dat, nb, 0);
        // later checks then look at settled outputs, never at a launching edge
        @(negedge clock);
    endtask : cmd

    task automatic rd_expect(input logic [7:0] v);
        exp_q.push_back(v);
        exp_q.push_back(v);
        flsw_host_model_i.xfer(8'h05, 8'h00, 0, 4);
        @(negedge clock);
    endtask : rd_expect

    task automatic wait_idle;
        for (k = 0; k < 300 && flash_status[0] !== 1'b0; k++) @(negedge clock);
        if (k == 300) begin
            fail_count++;
            $display("[ERR] busy wait expected 00 seen 01");
            print_verdict();
        end
    endtask : wait_idle

    always @(posedge rd_strobe) begin
        if (exp_q.size() == 0) begin
            fail_count++;
            $display("[ERR] status read expected none seen %h", rd_byte);
        end else begin
            check("status read", rd_byte, exp_q.pop_front());
        end
    end

    initial begin
        resetn = 1'b0;
        wp_drive = 1'b1;
        hold_drive = 1'b1;
        last_so = 1'b0;
        fail_count = 0;
        tests_run = 0;
        n_ops = 0;
        seed = 58280;
        repeat (5) @(negedge clock);
        resetn = 1'b1;
        repeat (3) @(negedge clock);
        check("status", flash_status, 8'h00);
        check("quad", {7'h00, quad_mode}, 8'h00);
        check("protect", {7'h00, protect_any}, 8'h00);
        rd_expect(8'h00);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            cmd(guard_ops[i], 8'h00, 1);
            check("dropped op", flash_status, 8'h00);
            check("op_start", n_ops[7:0], 8'(i));
            cmd(8'h06, 8'h00, 0);
            check("latch set", flash_status, 8'h02);
            cmd(guard_ops[i], 8'h00, 1);
            check("op_start", n_ops[7:0], 8'(i + 1));
            wait_idle();
            check("op done", flash_status, 8'h00);
        end
        $display("test guarded set done");
        d = $random(seed);
        d = {1'b0, d[6:2], 2'b00};
        cmd(8'h01, d, 1);
        check("write no latch", flash_status, 8'h00);
        cmd(8'h06, 8'h00, 0);
        cmd(8'h01, d, 1);
        check("write busy", flash_status, d | 8'h03);
        check("op_data", op_data, d);
        check("op_code", op_code, 8'h01);
        cmd(8'h04, 8'h00, 0);
        check("busy refuse", flash_status, d | 8'h03);
        wait_idle();
        check("write done", flash_status, d);
        check("quad", {7'h00, quad_mode}, {7'h00, d[6]});
        check("protect", {7'h00, protect_any}, {7'h00, |d[5:2]});
        rd_expect(d);
        $display("test status write done");
        cmd(8'h06, 8'h00, 0);
        cmd(8'h01, 8'h80, 1);
        wait_idle();
        check("lockout", flash_status, 8'h80);
        @(negedge clock) wp_drive = 1'b0;
        cmd(8'h06, 8'h00, 0);
        cmd(8'h01, 8'h3C, 1);
        check("locked write", flash_status, 8'h82);
        @(negedge clock) wp_drive = 1'b1;
        cmd(8'h01, 8'h3C, 1);
        wait_idle();
        check("pin high write", flash_status, 8'h3C);
        check("protect", {7'h00, protect_any}, 8'h01);
        $display("test lockout done");
        cmd(8'h06, 8'h00, 0);
        cmd(8'hC7, 8'h00, 0);
        check("erase refused", flash_status, 8'h3E);
        check("op_start", n_ops[7:0], 8'h09);
        cmd(8'h01, 8'h00, 1);
        wait_idle();
        cmd(8'h06, 8'h00, 0);
        cmd(8'h60, 8'h00, 0);
        check("op_start", n_ops[7:0], 8'h0B);
        wait_idle();
        check("erase done", flash_status, 8'h00);
        $display("test full erase done");
        cmd(8'hC0, 8'h00, 1);
        cmd(8'h17, 8'h00, 1);
        check("op_start", n_ops[7:0], 8'h0D);
        cmd(8'h63, 8'h00, 1);
        check("op_start", n_ops[7:0], 8'h0D);
        cmd(8'h06, 8'h00, 0);
        cmd(8'h04, 8'h00, 0);
        check("latch clear", flash_status, 8'h00);
        $display("test volatile done");
        cmd(8'h06, 8'h00, 0);
        cmd(8'h02, 8'hA5, 4);
        check("program busy", flash_status, 8'h03);
        cmd(8'h75, 8'h00, 0);
        check("suspended", flash_status, 8'h02);
        cmd(8'h7A, 8'h00, 0);
        check("resumed", flash_status, 8'h03);
        wait_idle();
        check("program done", flash_status, 8'h00);
        $display("test suspend done");
        cmd(8'h06, 8'h00, 0);
        cmd(8'hD8, 8'h00, 3);
        check("erase busy", flash_status, 8'h03);
        cmd(8'h66, 8'h00, 0);
        cmd(8'h99, 8'h00, 0);
        check("reset while busy", flash_status, 8'h00);
        check("op_start", n_ops[7:0], 8'h0F);
        $display("test soft reset done");
        cmd(8'h06, 8'h00, 0);
        cmd(8'h01, 8'hC0, 1);
        wait_idle();
        check("quad lockout", flash_status, 8'hC0);
        check("quad", {7'h00, quad_mode}, 8'h01);
        @(negedge clock) wp_drive = 1'b0;
        cmd(8'h06, 8'h00, 0);
        cmd(8'h01, 8'h3C, 1);
        wait_idle();
        check("quad ignores pin", flash_status, 8'h3C);
        check("pins 2 3", {4'h0, d2_o, d2_oe, d3_o, d3_oe}, 8'h00);
        $display("test quad done");
        print_verdict();
    end
endmodule : flash_status_write_enable_tb_top
`default_nettype wire
